// [rtl/l2te_pkg.sv]
// l2te_pkg: widths, reset values, enums and carrier structs for the cache error report block.
// assumes one core clock; all access fields arrive registered and synchronous to mclk.
// Functional notes
// - every access checks single-error-correcting ECC on all 16 tags of the set.
// - tag correctable error logs tag type and PA 21:6, no syndrome.
// - a tag correction repairs every erroneous tag of the set.
// - tag error reported at once; correction written back only on a miss.
// - correctable enable sends corrected report to the steered virtual processor.
// - record enable and clear status valid flag encode corrected type; address undefined.
// - corrected trap taken when trap enable and (interrupts on or not hyperprivileged).
// - blocked trap stays pending; dropped when status valid clears, taken when allowed.
// - either enable clear: no report, but status and address still updated.
// - every first-pass access checks ECC over 32 valid/dirty and 32 used/allocate bits.
// - state-bit correctable error logs state type, syndrome and PA 39:6.
// - state-bit single error corrected over the set on hit or miss; report gating same as tags.
// - state-bit ECC checked only on the first pipeline pass.
// - data uncorrectable on core access captures type, rw, id, mode, syndrome, PA.
// - uncorrectable enable sends error to requester; else ignored but captured.
// - precise trap and fault status for fetch and load hits need uncorrectable, record and precise enables.
// - instruction walk error with both enables: instruction MMU trap, walk type.
// - data walk error: data MMU trap, walk type; fault address not logged.
// - fetch hit error: fill L1 instruction line bad parity; precise access trap.
// - load hit error: fill L1 data line bad parity; precise data access trap.
// - walk or fetch error without uncorrectable enable: no report, no trap; without record enable: reported, but no trap or bad fill.
// - a hard tag failure leaves correction incomplete and hangs the bank.
package l2te_pkg;
  localparam int TAG_N = 16;
  localparam int TAG_D = 22;
  localparam int TAG_C = 5;
  localparam int TAG_CW = TAG_D + TAG_C;
  localparam int ST_D = 32;
  localparam int ST_C = 6;
  localparam int ST_CW = ST_D + ST_C;
  localparam int SYND_W = 12;
  localparam int REQ_W = 6;
  localparam int ADDR_W = 34;       // PA 39:6
  localparam int TAG_ADDR_W = 16;   // PA 21:6
  localparam int INDEX_W = 9;
  localparam int INDEX_LSB = 0;     // set index sits at PA bit 6
  localparam logic [ADDR_W-1:0] ERR_ADDR_RST = 34'h0;
  localparam logic [SYND_W-1:0] SYND_RST = 12'h000;
  localparam logic [REQ_W-1:0] VP_RST = 6'h00;

  typedef enum logic [1:0] {ERR_NONE, ERR_TAG_CORR, ERR_STATE_CORR, ERR_ACCESS_UNCORR} l2te_err_t;
  typedef enum logic [2:0] {ACC_OTHER, ACC_FETCH_HIT, ACC_LOAD_HIT, ACC_INSTR_WALK, ACC_DATA_WALK} l2te_kind_t;
  typedef enum logic [2:0] {FLT_NONE, FLT_INSTR_WALK_UNCORR, FLT_DATA_WALK_UNCORR, FLT_FETCH_HIT_UNCORR,
                            FLT_LOAD_HIT_UNCORR} l2te_fault_t;
  typedef enum logic [1:0] {TRAP_INSTR_MMU, TRAP_DATA_MMU, TRAP_INSTR_ACCESS, TRAP_DATA_ACCESS} l2te_trap_t;
  typedef enum logic {BANK_RUN, BANK_HUNG} l2te_bank_t;

  typedef struct packed {
    logic valid;
    logic firstPass;
    logic hit;
    logic rw;
    logic [REQ_W-1:0] reqId;
    logic modeFlag;
    l2te_kind_t kind;
    logic [ADDR_W-1:0] pa;
    logic dataUncorr;
    logic [SYND_W-1:0] dataSynd;
  } l2te_access_t;

  typedef struct packed {
    logic ceEnable;
    logic ueEnable;
    logic corrRecordEn;
    logic walkRecordEn;
    logic fetchRecordEn;
    logic loadRecordEn;
    logic hwCorrTrapEn;
    logic preciseTrapEn;
    logic intEnable;
    logic hyperPriv;
    logic [REQ_W-1:0] errorSteer;
  } l2te_enables_t;

  typedef struct packed {
    l2te_err_t errType;
    logic rw;
    logic [REQ_W-1:0] reqId;
    logic modeFlag;
    logic [SYND_W-1:0] synd;
  } l2te_status_t;
endpackage

// [rtl/l2te_sec_fix.sv]
// l2te_sec_fix: single-error-correcting check and repair of one codeword {check, data}.
// assumes a purely combinational use; the caller registers the results.
`timescale 1ns/10ps
module l2te_sec_fix #(
  parameter int D = 22,
  parameter int C = 5
) (
  input wire logic [D+C-1:0] code,
  output logic [D+C-1:0] fixedCode,
  output logic [C-1:0] syndrome,
  output logic single,
  output logic uncorr
);
  // i-th data bit sits at the i-th position that is not a power of two
  function automatic logic [C-1:0] posOf(input int idx);
    int n;
    logic [C-1:0] r;
    n = 0;
    r = '0;
    for (int k = 3; k < 2**C; k++) begin
      if ((k & (k - 1)) != 0) begin
        if (n == idx) r = k[C-1:0];
        n++;
      end
    end
    return r;
  endfunction

  function automatic logic [C-1:0] calcCheck(input logic [D-1:0] d);
    logic [C-1:0] c;
    c = '0;
    for (int i = 0; i < D; i++) begin
      if (d[i]) c = c ^ posOf(i);
    end
    return c;
  endfunction

  // syndrome, flip of the matching data bit, regenerated check bits
  always_comb begin
    logic [D-1:0] fd;
    logic hitBit;
    fd = code[D-1:0];
    hitBit = 1'b0;
    syndrome = calcCheck(code[D-1:0]) ^ code[D+C-1:D];
    for (int i = 0; i < D; i++) begin
      if (syndrome != '0 && syndrome == posOf(i)) begin
        fd[i] = ~fd[i];
        hitBit = 1'b1;
      end
    end
    single = (syndrome != '0) && (hitBit || ((syndrome & (syndrome - 1'b1)) == '0));
    uncorr = (syndrome != '0) && !single;
    fixedCode = {calcCheck(fd), fd};
  end
endmodule

// [rtl/l2te_error_report.sv]
// l2te_error_report: tag and state-bit correction, uncorrectable data reporting and trap gating.
// assumes the cache pipeline presents one access per enabled cycle with its set's tags and state codes.
`timescale 1ns/10ps
module l2te_error_report (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire l2te_pkg::l2te_access_t acc,
  input wire logic [l2te_pkg::TAG_N*l2te_pkg::TAG_CW-1:0] tagCode,
  input wire logic [l2te_pkg::ST_CW-1:0] vdCode,
  input wire logic [l2te_pkg::ST_CW-1:0] uaCode,
  input wire l2te_pkg::l2te_enables_t en,
  input wire logic descClear,
  output l2te_pkg::l2te_status_t errStatus,
  output logic [l2te_pkg::ADDR_W-1:0] errAddr,
  output logic errCapture,
  output logic corrReport,
  output logic [l2te_pkg::REQ_W-1:0] corrReportVp,
  output logic descValid,
  output logic hwCorrTrap,
  output logic [l2te_pkg::REQ_W-1:0] hwCorrTrapVp,
  output logic ueReport,
  output logic [l2te_pkg::REQ_W-1:0] ueReportVp,
  output logic preciseTrap,
  output l2te_pkg::l2te_trap_t preciseTrapKind,
  output logic [l2te_pkg::REQ_W-1:0] preciseTrapVp,
  output logic instrFaultWr,
  output l2te_pkg::l2te_fault_t instrFault,
  output logic dataFaultWr,
  output l2te_pkg::l2te_fault_t dataFault,
  output logic icBadFill,
  output logic dcBadFill,
  output logic tagFixWr,
  output logic [l2te_pkg::INDEX_W-1:0] tagFixIndex,
  output logic [l2te_pkg::TAG_N*l2te_pkg::TAG_CW-1:0] tagFixCode,
  output logic stateFixWr,
  output logic [l2te_pkg::INDEX_W-1:0] stateFixIndex,
  output logic [l2te_pkg::ST_CW-1:0] vdFixCode,
  output logic [l2te_pkg::ST_CW-1:0] uaFixCode,
  output logic bankHung
);
  logic [l2te_pkg::TAG_N-1:0] tagSingle;
  logic [l2te_pkg::TAG_N*l2te_pkg::TAG_CW-1:0] tagFixed;
  logic [l2te_pkg::ST_CW-1:0] vdFixed;
  logic [l2te_pkg::ST_CW-1:0] uaFixed;
  logic [l2te_pkg::ST_C-1:0] vdSyn;
  logic [l2te_pkg::ST_C-1:0] uaSyn;
  logic vdSingle;
  logic uaSingle;

  // one checker per tag of the set
  for (genvar g = 0; g < l2te_pkg::TAG_N; g++) begin : gTag
    l2te_sec_fix #(.D(l2te_pkg::TAG_D), .C(l2te_pkg::TAG_C)) uTag (
      .code(tagCode[g*l2te_pkg::TAG_CW +: l2te_pkg::TAG_CW]),
      .fixedCode(tagFixed[g*l2te_pkg::TAG_CW +: l2te_pkg::TAG_CW]),
      .syndrome(),
      .single(tagSingle[g]),
      .uncorr()
    );
  end

  // valid/dirty and used/allocate checkers
  l2te_sec_fix #(.D(l2te_pkg::ST_D), .C(l2te_pkg::ST_C)) uVd (
    .code(vdCode),
    .fixedCode(vdFixed),
    .syndrome(vdSyn),
    .single(vdSingle),
    .uncorr()
  );
  l2te_sec_fix #(.D(l2te_pkg::ST_D), .C(l2te_pkg::ST_C)) uUa (
    .code(uaCode),
    .fixedCode(uaFixed),
    .syndrome(uaSyn),
    .single(uaSingle),
    .uncorr()
  );

  // state registers
  l2te_pkg::l2te_bank_t bank_r, bank_nxt;
  l2te_pkg::l2te_status_t errStatus_r, errStatus_nxt;
  logic [l2te_pkg::ADDR_W-1:0] errAddr_r, errAddr_nxt;
  logic errCapture_r, corrReport_r, descValid_r, pend_r, hwCorrTrap_r, ueReport_r;
  logic preciseTrap_r, instrFaultWr_r, dataFaultWr_r, icBadFill_r, dcBadFill_r;
  logic tagFixWr_r, stateFixWr_r, fixArmed_r;
  logic [l2te_pkg::REQ_W-1:0] corrReportVp_r, pendVp_r, hwCorrTrapVp_r, ueReportVp_r, preciseTrapVp_r;
  l2te_pkg::l2te_trap_t preciseTrapKind_r, trapKind;
  l2te_pkg::l2te_fault_t instrFault_r, dataFault_r, faultKind;
  logic [l2te_pkg::INDEX_W-1:0] tagFixIndex_r, stateFixIndex_r, fixIndex_r;
  logic [l2te_pkg::TAG_N*l2te_pkg::TAG_CW-1:0] tagFixCode_r;
  logic [l2te_pkg::ST_CW-1:0] vdFixCode_r, uaFixCode_r;

  // access qualification; a hung bank takes nothing more
  wire accOk = acc.valid && (bank_r == l2te_pkg::BANK_RUN);
  wire [l2te_pkg::INDEX_W-1:0] accIndex = acc.pa[l2te_pkg::INDEX_LSB +: l2te_pkg::INDEX_W];
  wire tagErr = accOk && (|tagSingle);
  wire stateErr = accOk && acc.firstPass && (vdSingle || uaSingle);
  wire ueHit = accOk && acc.dataUncorr;
  wire corrHit = tagErr || stateErr;
  wire isWalk = (acc.kind == l2te_pkg::ACC_INSTR_WALK) || (acc.kind == l2te_pkg::ACC_DATA_WALK);
  wire isFetch = (acc.kind == l2te_pkg::ACC_FETCH_HIT);
  wire isLoad = (acc.kind == l2te_pkg::ACC_LOAD_HIT);

  // corrected-error gating shared by tag and state errors
  wire corrGo = corrHit && en.ceEnable && en.corrRecordEn;
  wire descLive = descValid_r && !descClear;
  wire newRecord = corrGo && !descLive;
  wire descValid_nxt = descLive || newRecord;
  wire pendNow = (pend_r && descLive) || newRecord;
  wire trapAllow = en.hwCorrTrapEn && (en.intEnable || !en.hyperPriv);
  wire trapFire = pendNow && trapAllow;
  wire pend_nxt = pendNow && !trapFire;
  wire [l2te_pkg::REQ_W-1:0] pendVp_nxt = newRecord ? en.errorSteer : pendVp_r;

  // uncorrectable gating per access kind
  wire kindRecEn = isWalk ? en.walkRecordEn : isFetch ? en.fetchRecordEn : isLoad ? en.loadRecordEn : 1'b0;
  wire ueTwo = ueHit && en.ueEnable && kindRecEn;
  wire walkTrap = ueTwo && isWalk;
  wire hitTrap = ueTwo && (isFetch || isLoad) && en.preciseTrapEn;
  wire faultGo = walkTrap || hitTrap;
  wire instrSide = (acc.kind == l2te_pkg::ACC_INSTR_WALK) || isFetch;

  // trap and fault encodings for the access kind
  always_comb begin
    case (acc.kind)
      l2te_pkg::ACC_INSTR_WALK: begin
        trapKind = l2te_pkg::TRAP_INSTR_MMU;
        faultKind = l2te_pkg::FLT_INSTR_WALK_UNCORR;
      end
      l2te_pkg::ACC_DATA_WALK: begin
        trapKind = l2te_pkg::TRAP_DATA_MMU;
        faultKind = l2te_pkg::FLT_DATA_WALK_UNCORR;
      end
      l2te_pkg::ACC_FETCH_HIT: begin
        trapKind = l2te_pkg::TRAP_INSTR_ACCESS;
        faultKind = l2te_pkg::FLT_FETCH_HIT_UNCORR;
      end
      default: begin
        trapKind = l2te_pkg::TRAP_DATA_ACCESS;
        faultKind = l2te_pkg::FLT_LOAD_HIT_UNCORR;
      end
    endcase
  end

  // status/address capture, newest error wins; data error over state over tag
  wire errCap = ueHit || corrHit;
  always_comb begin
    errStatus_nxt = errStatus_r;
    errAddr_nxt = errAddr_r;
    if (ueHit) begin
      errStatus_nxt = '{l2te_pkg::ERR_ACCESS_UNCORR, acc.rw, acc.reqId, acc.modeFlag, acc.dataSynd};
      errAddr_nxt = acc.pa;
    end else if (stateErr) begin
      errStatus_nxt = '{l2te_pkg::ERR_STATE_CORR, acc.rw, acc.reqId, acc.modeFlag, {uaSyn, vdSyn}};
      errAddr_nxt = acc.pa;
    end else if (tagErr) begin
      errStatus_nxt = '{l2te_pkg::ERR_TAG_CORR, acc.rw, acc.reqId, acc.modeFlag, l2te_pkg::SYND_RST};
      errAddr_nxt = {{(l2te_pkg::ADDR_W-l2te_pkg::TAG_ADDR_W){1'b0}}, acc.pa[l2te_pkg::TAG_ADDR_W-1:0]};
    end
  end

  // a later miss at the repaired index that still finds a bad tag, before any clean access there, marks a hard failure
  wire tagMissFix = tagErr && !acc.hit;
  always_comb begin
    case (bank_r)
      l2te_pkg::BANK_RUN: begin
        bank_nxt = (tagMissFix && fixArmed_r && fixIndex_r == accIndex) ? l2te_pkg::BANK_HUNG : l2te_pkg::BANK_RUN;
      end
      l2te_pkg::BANK_HUNG: bank_nxt = l2te_pkg::BANK_HUNG;
      default: bank_nxt = l2te_pkg::BANK_RUN;
    endcase
  end

  // capture and reporting registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      errStatus_r <= '{l2te_pkg::ERR_NONE, 1'b0, l2te_pkg::VP_RST, 1'b0, l2te_pkg::SYND_RST};
      errAddr_r <= l2te_pkg::ERR_ADDR_RST;
      errCapture_r <= 1'b0;
      corrReport_r <= 1'b0;
      corrReportVp_r <= l2te_pkg::VP_RST;
      ueReport_r <= 1'b0;
      ueReportVp_r <= l2te_pkg::VP_RST;
    end else if (ce) begin
      errStatus_r <= errStatus_nxt;
      errAddr_r <= errAddr_nxt;
      errCapture_r <= errCap;
      corrReport_r <= corrGo;
      corrReportVp_r <= corrGo ? en.errorSteer : corrReportVp_r;
      ueReport_r <= ueHit && en.ueEnable;
      ueReportVp_r <= ueHit ? acc.reqId : ueReportVp_r;
    end
  end

  // disrupting status flag and pending corrected trap
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      descValid_r <= 1'b0;
      pend_r <= 1'b0;
      pendVp_r <= l2te_pkg::VP_RST;
      hwCorrTrap_r <= 1'b0;
      hwCorrTrapVp_r <= l2te_pkg::VP_RST;
    end else if (ce) begin
      descValid_r <= descValid_nxt;
      pend_r <= pend_nxt;
      pendVp_r <= pendVp_nxt;
      hwCorrTrap_r <= trapFire;
      hwCorrTrapVp_r <= trapFire ? pendVp_nxt : hwCorrTrapVp_r;
    end
  end

  // precise traps, fault status and bad-parity fills
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      preciseTrap_r <= 1'b0;
      preciseTrapKind_r <= l2te_pkg::TRAP_INSTR_MMU;
      preciseTrapVp_r <= l2te_pkg::VP_RST;
      instrFaultWr_r <= 1'b0;
      instrFault_r <= l2te_pkg::FLT_NONE;
      dataFaultWr_r <= 1'b0;
      dataFault_r <= l2te_pkg::FLT_NONE;
      icBadFill_r <= 1'b0;
      dcBadFill_r <= 1'b0;
    end else if (ce) begin
      preciseTrap_r <= faultGo;
      preciseTrapKind_r <= faultGo ? trapKind : preciseTrapKind_r;
      preciseTrapVp_r <= faultGo ? acc.reqId : preciseTrapVp_r;
      instrFaultWr_r <= faultGo && instrSide;
      instrFault_r <= (faultGo && instrSide) ? faultKind : instrFault_r;
      dataFaultWr_r <= faultGo && !instrSide;
      dataFault_r <= (faultGo && !instrSide) ? faultKind : dataFault_r;
      icBadFill_r <= ueTwo && isFetch;
      dcBadFill_r <= ueTwo && isLoad;
    end
  end

  // correction write-back and bank state
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tagFixWr_r <= 1'b0;
      tagFixIndex_r <= '0;
      tagFixCode_r <= '0;
      stateFixWr_r <= 1'b0;
      stateFixIndex_r <= '0;
      vdFixCode_r <= '0;
      uaFixCode_r <= '0;
      fixArmed_r <= 1'b0;
      fixIndex_r <= '0;
      bank_r <= l2te_pkg::BANK_RUN;
    end else if (ce) begin
      tagFixWr_r <= tagMissFix;
      tagFixIndex_r <= tagMissFix ? accIndex : tagFixIndex_r;
      tagFixCode_r <= tagMissFix ? tagFixed : tagFixCode_r;
      stateFixWr_r <= stateErr;
      stateFixIndex_r <= stateErr ? accIndex : stateFixIndex_r;
      vdFixCode_r <= stateErr ? vdFixed : vdFixCode_r;
      uaFixCode_r <= stateErr ? uaFixed : uaFixCode_r;
      fixArmed_r <= tagMissFix ? 1'b1 : (accOk && accIndex == fixIndex_r && !tagErr) ? 1'b0 : fixArmed_r;
      fixIndex_r <= tagMissFix ? accIndex : fixIndex_r;
      bank_r <= bank_nxt;
    end
  end

  assign errStatus = errStatus_r;
  assign errAddr = errAddr_r;
  assign errCapture = errCapture_r;
  assign corrReport = corrReport_r;
  assign corrReportVp = corrReportVp_r;
  assign descValid = descValid_r;
  assign hwCorrTrap = hwCorrTrap_r;
  assign hwCorrTrapVp = hwCorrTrapVp_r;
  assign ueReport = ueReport_r;
  assign ueReportVp = ueReportVp_r;
  assign preciseTrap = preciseTrap_r;
  assign preciseTrapKind = preciseTrapKind_r;
  assign preciseTrapVp = preciseTrapVp_r;
  assign instrFaultWr = instrFaultWr_r;
  assign instrFault = instrFault_r;
  assign dataFaultWr = dataFaultWr_r;
  assign dataFault = dataFault_r;
  assign icBadFill = icBadFill_r;
  assign dcBadFill = dcBadFill_r;
  assign tagFixWr = tagFixWr_r;
  assign tagFixIndex = tagFixIndex_r;
  assign tagFixCode = tagFixCode_r;
  assign stateFixWr = stateFixWr_r;
  assign stateFixIndex = stateFixIndex_r;
  assign vdFixCode = vdFixCode_r;
  assign uaFixCode = uaFixCode_r;
  assign bankHung = (bank_r == l2te_pkg::BANK_HUNG);

  // checks on the driven outputs
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  chk_tag_miss_only: assert property ($past(ce) && tagFixWr |-> $past(acc.valid && !acc.hit))
    else $error("tag write-back without a miss");
  chk_tag_addr_low: assert property (errCapture && errStatus.errType == l2te_pkg::ERR_TAG_CORR
    |-> errAddr[l2te_pkg::ADDR_W-1:l2te_pkg::TAG_ADDR_W] == '0 && errStatus.synd == '0)
    else $error("tag error logged wide address or syndrome");
  chk_corr_report_gate: assert property ($past(ce) && corrReport |-> $past(en.ceEnable && en.corrRecordEn))
    else $error("corrected report while disabled");
  chk_hw_trap_gate: assert property ($past(ce) && hwCorrTrap
    |-> $past(en.hwCorrTrapEn && (en.intEnable || !en.hyperPriv)) && descValid)
    else $error("corrected trap taken while blocked");
  chk_pend_dropped: assert property (ce && descValid && descClear && !corrGo |=> !pend_r && !descValid)
    else $error("pending trap survived status clear");
  chk_ue_capture: assert property (ce && ueHit |=> errCapture
    && errStatus.errType == l2te_pkg::ERR_ACCESS_UNCORR && errAddr == $past(acc.pa))
    else $error("uncorrectable access not captured");
  chk_precise_gate: assert property ($past(ce) && preciseTrap
    && preciseTrapKind inside {l2te_pkg::TRAP_INSTR_ACCESS, l2te_pkg::TRAP_DATA_ACCESS}
    |-> $past(en.preciseTrapEn && en.ueEnable))
    else $error("precise access trap without enables");
  chk_walk_trap: assert property (ce && ueHit && isWalk && en.ueEnable && en.walkRecordEn
    |=> preciseTrap && (instrFaultWr || dataFaultWr))
    else $error("walk error did not trap");
  chk_state_first: assert property ($past(ce) && stateFixWr |-> $past(acc.firstPass))
    else $error("state check on a later pass");
  chk_hung_stays: assert property (bankHung |=> bankHung [*3])
    else $error("hung bank resumed");
  chk_no_fill_gated: assert property ($past(ce) && (icBadFill || dcBadFill)
    |-> $past(en.ueEnable && kindRecEn))
    else $error("bad fill without enables");

  cov_tag_fix: cover property (tagFixWr);
  cov_trap_pended: cover property (pend_r && !trapAllow ##1 hwCorrTrap);
  cov_precise: cover property (preciseTrap && dcBadFill);
  cov_hung: cover property (bankHung);
endmodule

// [tb/l2te_core_model.sv]
// l2te_core_model: stands in for the steered virtual processor; counts corrected traps, clears status.
// assumes trap pulses last one mclk and that the bench asks for status clears.
`timescale 1ns/10ps
module l2te_core_model (
  input wire logic mclk,
  input wire logic rst,
  input wire logic hwCorrTrap,
  input wire logic descValid,
  input wire logic clrReq,
  output logic descClear,
  output int trapCnt
);
  // software clears the status valid flag only while it is set
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      descClear <= 1'b0;
      trapCnt <= 0;
    end else begin
      descClear <= clrReq && descValid;
      trapCnt <= trapCnt + int'(hwCorrTrap);
    end
  end
endmodule

// [tb/testbench.sv]
// testbench: random and corner accesses against l2te_error_report, expectations from bench ECC math.
// assumes l2te_core_model answers the corrected trap side; inputs change on the falling edge.
`timescale 1ns/10ps
module testbench;
  localparam int TW = l2te_pkg::TAG_N * l2te_pkg::TAG_CW;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic clrReq = 1'b0;
  logic descClear;
  int trapCnt;
  int fails = 0;
  int cmp_count = 0;
  logic [31:0] rs = 32'hfef6;
  l2te_pkg::l2te_access_t acc = '0;
  l2te_pkg::l2te_enables_t en = '0;
  logic [TW-1:0] tagCode = '0;
  logic [TW-1:0] good;
  logic [75:0] goodS;
  logic [37:0] vdCode = '0;
  logic [37:0] uaCode = '0;
  logic [33:0] pa = '0;
  l2te_pkg::l2te_status_t errStatus;
  logic [33:0] errAddr;
  logic errCapture, corrReport, descValid, hwCorrTrap, ueReport, preciseTrap, instrFaultWr, dataFaultWr;
  logic icBadFill, dcBadFill, tagFixWr, stateFixWr, bankHung;
  logic [5:0] corrReportVp, hwCorrTrapVp, ueReportVp, preciseTrapVp;
  l2te_pkg::l2te_trap_t preciseTrapKind;
  l2te_pkg::l2te_fault_t instrFault, dataFault;
  logic [8:0] tagFixIndex, stateFixIndex;
  logic [TW-1:0] tagFixCode;
  logic [37:0] vdFixCode, uaFixCode;
  l2te_pkg::l2te_trap_t tk[1:4] = '{l2te_pkg::TRAP_INSTR_ACCESS, l2te_pkg::TRAP_DATA_ACCESS,
    l2te_pkg::TRAP_INSTR_MMU, l2te_pkg::TRAP_DATA_MMU};
  l2te_pkg::l2te_fault_t fk[1:4] = '{l2te_pkg::FLT_FETCH_HIT_UNCORR, l2te_pkg::FLT_LOAD_HIT_UNCORR,
    l2te_pkg::FLT_INSTR_WALK_UNCORR, l2te_pkg::FLT_DATA_WALK_UNCORR};

  always #2.5 mclk = ~mclk;

  l2te_error_report dut_u (.mclk, .rst, .ce, .acc, .tagCode, .vdCode, .uaCode, .en, .descClear,
    .errStatus, .errAddr, .errCapture, .corrReport, .corrReportVp, .descValid, .hwCorrTrap,
    .hwCorrTrapVp, .ueReport, .ueReportVp, .preciseTrap, .preciseTrapKind, .preciseTrapVp,
    .instrFaultWr, .instrFault, .dataFaultWr, .dataFault, .icBadFill, .dcBadFill, .tagFixWr,
    .tagFixIndex, .tagFixCode, .stateFixWr, .stateFixIndex, .vdFixCode, .uaFixCode, .bankHung);
  l2te_core_model core_u (.mclk, .rst, .hwCorrTrap, .descValid, .clrReq, .descClear, .trapCnt);

  // xorshift source, fixed seed
  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction

  // check bits: xor of the codeword positions of set data bits, powers of two skipped
  function automatic logic [5:0] ham(input logic [31:0] d, input int n);
    int p;
    ham = 6'h00;
    p = 2;
    for (int i = 0; i < n; i++) begin
      p++;
      if ((p & (p - 1)) == 0) p++;
      if (d[i]) ham ^= p[5:0];
    end
  endfunction

  task automatic chk(input logic [TW-1:0] g, input logic [TW-1:0] e);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic wt(input int n);
    acc.valid = 1'b0;
    repeat (n) @(negedge mclk);
  endtask

  // fresh clean set of 16 tags and both state words
  task automatic mkset();
    logic [5:0] c;
    logic [31:0] d;
    for (int g = 0; g < 16; g++) begin
      d = rnd();
      c = ham(d, 22);
      tagCode[g*27+:27] = {c[4:0], d[21:0]};
    end
    d = rnd();
    vdCode = {ham(d, 32), d};
    d = rnd();
    uaCode = {ham(d, 32), d};
    good = tagCode;
    goodS = {vdCode, uaCode};
  endtask

  // one access from a falling edge; its answer is settled at the next falling edge
  // valid stays up until the next access or wait, so acc is written once per edge
  task automatic go(input logic hit, input logic fp, input logic [2:0] k, input logic ue);
    acc = {1'b1, fp, hit, 1'(rnd()), 6'(rnd()), 1'(rnd()), k, pa, ue, 12'(rnd())};
    @(posedge mclk);
    @(negedge mclk);
  endtask

  initial begin
    int b;
    logic isI;
    logic xt;
    en = '1;
    en.hyperPriv = 1'b0;
    en.errorSteer = 6'(rnd());
    wt(8);
    rst = 1'b0;
    chk({errCapture, bankHung, errStatus.errType}, {2'b00, l2te_pkg::ERR_NONE});
    clrReq = 1'b1;
    // tag errors in two ways of the set, hits and misses in turn
    for (int n = 0; n < 8; n++) begin
      mkset();
      pa = 34'({rnd(), rnd()});
      b = rnd() % 22;
      tagCode[(n % 16) * 27 + b] ^= 1'b1;
      tagCode[((n + 5) % 16) * 27 + 21 - b] ^= 1'b1;
      go(n[0], 1'b1, 3'h0, 1'b0);
      chk({errCapture, errStatus.errType}, {1'b1, l2te_pkg::ERR_TAG_CORR});
      chk({errAddr, errStatus.synd}, {18'h0, acc.pa[15:0], 12'h0});
      chk(tagFixWr, !n[0]);
      if (!n[0]) chk(tagFixCode, good);
      if (!n[0]) chk(tagFixIndex, acc.pa[8:0]);
      chk({corrReport, corrReportVp}, {1'b1, en.errorSteer});
      chk({descValid, hwCorrTrap, hwCorrTrapVp}, {2'b11, en.errorSteer});
      tagCode = good;
      go(1'b1, 1'b1, 3'h0, 1'b0);
      chk(errCapture, 0);
      wt(3);
    end
    // state-bit flips: replay pass first, then the first pass
    for (int n = 0; n < 6; n++) begin
      mkset();
      pa = 34'({rnd(), rnd()});
      b = rnd() % 32;
      if (n[0]) uaCode[b] ^= 1'b1;
      else vdCode[b] ^= 1'b1;
      go(1'b0, 1'b0, 3'h0, 1'b0);
      chk(errCapture, 0);
      go(n[1], 1'b1, 3'h0, 1'b0);
      chk(errStatus.errType, l2te_pkg::ERR_STATE_CORR);
      chk({errAddr, errStatus.synd}, {acc.pa, n[0] ? {ham(1 << b, 32), 6'h0} : {6'h0, ham(1 << b, 32)}});
      chk({stateFixWr, corrReport, stateFixIndex, vdFixCode, uaFixCode}, {2'b11, acc.pa[8:0], goodS});
      wt(3);
    end
    // report enable off: captured, not reported
    en.ceEnable = 1'b0;
    mkset();
    tagCode[3] ^= 1'b1;
    go(1'b1, 1'b1, 3'h0, 1'b0);
    chk({errCapture, corrReport, descValid}, 3'b100);
    en.ceEnable = 1'b1;
    // blocked trap waits, then fires once mode allows
    clrReq = 1'b0;
    en.hwCorrTrapEn = 1'b0;
    go(1'b1, 1'b1, 3'h0, 1'b0);
    chk({descValid, hwCorrTrap}, 2'b10);
    en.hyperPriv = 1'b1;
    en.intEnable = 1'b0;
    en.hwCorrTrapEn = 1'b1;
    b = trapCnt;
    wt(4);
    chk(trapCnt, b);
    en.hyperPriv = 1'b0;
    for (int i = 0; i < 6 && trapCnt == b; i++) wt(1);
    chk(trapCnt, b + 1);
    if (trapCnt == b) end_sim();
    // pending trap dropped by clearing the valid flag
    clrReq = 1'b1;
    wt(4);
    clrReq = 1'b0;
    en.hwCorrTrapEn = 1'b0;
    go(1'b1, 1'b1, 3'h0, 1'b0);
    clrReq = 1'b1;
    wt(4);
    en.hwCorrTrapEn = 1'b1;
    b = trapCnt;
    wt(4);
    chk({descValid, 32'(trapCnt)}, {1'b0, 32'(b)});
    // uncorrectable data per access kind: precise off, on, then record enables off
    mkset();
    for (int m = 0; m < 3; m++) begin
      en.preciseTrapEn = (m == 1);
      en.walkRecordEn = (m != 2);
      en.fetchRecordEn = (m != 2);
      en.loadRecordEn = (m != 2);
      for (int j = 1; j < 5; j++) begin
        isI = (j == 1 || j == 3);
        xt = (m != 2) && (j > 2 || m == 1);
        pa = 34'({rnd(), rnd()});
        go(1'b1, 1'b1, 3'(j), 1'b1);
        chk(errStatus, {l2te_pkg::ERR_ACCESS_UNCORR, acc.rw, acc.reqId, acc.modeFlag, acc.dataSynd});
        chk(errAddr, acc.pa);
        chk({ueReport, ueReportVp}, {1'b1, acc.reqId});
        chk({icBadFill, dcBadFill}, {j == 1 && m != 2, j == 2 && m != 2});
        chk({preciseTrap, instrFaultWr, dataFaultWr}, {xt, xt & isI, xt & !isI});
        if (xt) chk({preciseTrapKind, preciseTrapVp}, {tk[j], acc.reqId});
        if (xt) chk(isI ? instrFault : dataFault, fk[j]);
      end
    end
    en.ueEnable = 1'b0;
    en.walkRecordEn = 1'b1;
    go(1'b1, 1'b1, 3'h3, 1'b1);
    chk({errCapture, ueReport, preciseTrap}, 3'b100);
    // a frozen clock enable ignores an access; then a tag still bad after its write-back hangs the bank
    wt(1);
    mkset();
    tagCode[40] ^= 1'b1;
    ce = 1'b0;
    go(1'b0, 1'b1, 3'h0, 1'b0);
    chk({errCapture, tagFixWr, corrReport}, 3'b000);
    ce = 1'b1;
    go(1'b0, 1'b1, 3'h0, 1'b0);
    go(1'b0, 1'b1, 3'h0, 1'b0);
    chk(bankHung, 1);
    go(1'b0, 1'b1, 3'h0, 1'b1);
    chk(errCapture, 0);
    rst = 1'b1;
    wt(1);
    rst = 1'b0;
    chk(bankHung, 0);
    end_sim();
  end
endmodule
